// ### dv/dbim_props.sv
// Link checker: burst framing, flag coding and pin sharing
`timescale 1ns/100ps
`include "dbim_regs.svh"
module dbim_props (
  input wire logic ck,
  input wire logic nrst,
  input wire logic [2:0] cmd,
  input wire logic ctl_dq_oe_n,
  input wire logic ctl_dmdbi_oe_n,
  input wire logic dev_dq_oe_n,
  input wire logic dev_dmdbi_oe_n,
  input wire logic [15:0] dq,
  input wire logic [1:0] dmdbi
);
  logic [5:0] mode_q;
  logic [3:0] wcnt_q;
  logic mpr_q;
  default clocking @(posedge ck); endclocking
  default disable iff (!nrst);
  // Byte on the wire is legal for its flag level
  function automatic logic ok(input logic [7:0] b, input logic f);
    return f ? ($countones(~b) <= 4) : ($countones(~b) < 4);
  endfunction
  // Mode word as last sent over the link
  always_ff @(posedge ck) begin
    if (!nrst) mode_q <= 6'h00;
    else if (cmd == `DBIM_CMD_MRS) mode_q <= dq[5:0];
  end
  // Marks write beats 1..8 after the command
  always_ff @(posedge ck) begin
    if (!nrst) wcnt_q <= 4'h0;
    else if (wcnt_q == 4'h8) wcnt_q <= 4'h0;
    else if (wcnt_q != 4'h0) wcnt_q <= wcnt_q + 4'h1;
    else if (cmd == `DBIM_CMD_WR) wcnt_q <= 4'h1;
  end
  // Set by a readout command, cleared by an array read
  always_ff @(posedge ck) begin
    if (!nrst) mpr_q <= 1'b0;
    else if (cmd == `DBIM_CMD_MPR) mpr_q <= 1'b1;
    else if (cmd == `DBIM_CMD_RD) mpr_q <= 1'b0;
  end
  sequence rd_frame;
    dev_dq_oe_n [*3] ##1 !dev_dq_oe_n [*8] ##1 dev_dq_oe_n;
  endsequence
  sequence mpr_beat;
    dmdbi == 2'h3 && dq[7:0] == dq[15:8];
  endsequence
  rd_code_a: assert property (!dev_dq_oe_n && !dev_dmdbi_oe_n &&
    !mpr_q |-> ok(dq[7:0], dmdbi[0]) && ok(dq[15:8], dmdbi[1]))
    else $error("read byte and flag disagree");
  wr_code_a: assert property (mode_q[1] && wcnt_q != 4'h0 |->
    ok(dq[7:0], dmdbi[0]) && ok(dq[15:8], dmdbi[1]))
    else $error("write byte and flag disagree");
  plain_flag_a: assert property (wcnt_q != 4'h0 &&
    mode_q[2:1] == 2'h0 |-> dmdbi == 2'h3)
    else $error("flag pin not high with functions off");
  wr_burst_a: assert property (cmd == `DBIM_CMD_WR |->
    ##1 !ctl_dq_oe_n [*8])
    else $error("write burst not eight beats");
  rd_burst_a: assert property (cmd == `DBIM_CMD_RD |-> rd_frame)
    else $error("read burst framing wrong");
  mpr_plain_a: assert property (cmd == `DBIM_CMD_MPR |->
    ##3 mpr_beat [*8])
    else $error("readout data inverted");
  flag_oe_a: assert property ($fell(dev_dq_oe_n) |->
    dev_dmdbi_oe_n == !mode_q[0])
    else $error("read flag drive does not follow mode");
  flag_data_a: assert property (!dev_dmdbi_oe_n |-> !dev_dq_oe_n)
    else $error("read flag without data");
  rd_no_mask_a: assert property (!dev_dq_oe_n |->
    ctl_dmdbi_oe_n && ctl_dq_oe_n)
    else $error("controller drives during read");
endmodule

// ### dv/dram_bus_inversion_and_mask_bench.sv
// Bench: both link ends, plus a second link with a faulty sender
`timescale 1ns/100ps
`include "dbim_regs.svh"
module dram_bus_inversion_and_mask_bench;
  import dbim_pkg::*;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic dev_nrst = 1'b0;
  logic cfg_wr = 1'b0, wr_req = 1'b0, rd_req = 1'b0, mpr_req = 1'b0;
  logic [5:0] cfg_d = 6'h00;
  dbim_burst_t wr_data = '0, rd_data, arr_wdata, wd_b, last_b;
  dbim_burst_t mem = '0, exp_mem = '0;
  dbim_burst_t expq[$];
  dbim_be_t wr_be = '0, arr_be, be_b;
  dbim_mode_t cfg_q;
  logic busy, cfg_bad, rd_valid, arr_we, arr_re, crc_err, we_b, err_b;
  logic [7:0] mpr_data = 8'h01;
  logic [5:0] mt[8] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h14, 6'h12};
  int mismatches = 0, n_tests = 0, seed = 13165, nwe = 0, nre = 0;
  dbim_if lk ();
  dbim_if lk2 ();
  dbim_ctl_end u_dbim_ctl_end (.link(lk.ctl), .ref_clk(ref_clk),
    .nrst(nrst), .cfg_wr(cfg_wr), .cfg_d(cfg_d), .wr_req(wr_req),
    .wr_data(wr_data), .wr_be(wr_be), .rd_req(rd_req), .mpr_req(mpr_req),
    .busy(busy), .cfg_q(cfg_q), .cfg_bad(cfg_bad), .rd_valid(rd_valid),
    .rd_data(rd_data));
  dbim_dram_end u_dbim_dram_end (.link(lk.dev), .nrst(dev_nrst),
    .arr_we(arr_we), .arr_wdata(arr_wdata), .arr_be(arr_be),
    .arr_re(arr_re), .arr_rdata(mem), .mpr_data(mpr_data),
    .crc_err(crc_err));
  dbim_dram_end u_dbim_dram_end_b (.link(lk2.dev), .nrst(dev_nrst),
    .arr_we(we_b), .arr_wdata(wd_b), .arr_be(be_b), .arr_re(),
    .arr_rdata(mem), .mpr_data(mpr_data), .crc_err(err_b));
  dbim_props u_dbim_props (.ck(lk.ck), .nrst(dev_nrst), .cmd(lk.cmd),
    .ctl_dq_oe_n(lk.ctl_dq_oe_n), .ctl_dmdbi_oe_n(lk.ctl_dmdbi_oe_n),
    .dev_dq_oe_n(lk.dev_dq_oe_n), .dev_dmdbi_oe_n(lk.dev_dmdbi_oe_n),
    .dq(lk.dq), .dmdbi(lk.dmdbi));
  // Clocks
  always #10 ref_clk = ~ref_clk;
  always #3 lk2.ck = ~lk2.ck;
  // Array model: enabled bytes are stored, fetches counted
  always @(posedge lk.ck) begin
    if (arr_we === 1'b1) for (int i = 0; i < 16; i++)
      if (arr_be[i]) mem[i*8 +: 8] <= arr_wdata[i*8 +: 8];
    if (arr_re === 1'b1) nre <= nre + 1;
  end
  // Commits seen on the second link
  always @(posedge lk2.ck) begin
    if (we_b === 1'b1) nwe <= nwe + 1;
    if (we_b === 1'b1) last_b <= wd_b;
  end
  task chk(input string n, input logic [127:0] s, input logic [127:0] e);
    n_tests++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task end_sim;
    if (mismatches == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Read results against the oldest note
  always @(posedge ref_clk) begin
    if (rd_valid === 1'b1 && expq.size() == 0) chk("rd_none", 1, 0);
    else if (rd_valid === 1'b1)
      chk("rd_data", rd_data, expq.pop_front());
  end
  // One request, then a bounded wait for busy to drop
  task req(input int k, input logic [5:0] m, input dbim_burst_t d,
    input dbim_be_t b);
    int i;
    @(posedge ref_clk);
    cfg_d <= m;
    wr_data <= d;
    wr_be <= b;
    {cfg_wr, wr_req, rd_req, mpr_req} <= 4'h8 >> k;
    @(posedge ref_clk);
    {cfg_wr, wr_req, rd_req, mpr_req} <= 4'h0;
    repeat (2) @(posedge ref_clk);
    i = 0;
    do begin
      @(negedge ref_clk);
      i++;
    end while (busy !== 1'b0 && i < 200);
    if (i == 200) chk("busy_hang", 1, 0);
    if (i == 200) end_sim();
  endtask
  // Second link: one tick driven just after the rising edge
  task tick(input logic [2:0] c, input logic [15:0] v, input logic on);
    @(posedge lk2.ck);
    lk2.cmd <= c;
    lk2.ctl_dq_o <= v;
    lk2.ctl_dq_oe_n <= !on;
    lk2.ctl_dmdbi_oe_n <= !on;
  endtask
  task lk_mrs(input logic [5:0] m);
    tick(`DBIM_CMD_MRS, {10'h000, m}, 1'b1);
    tick(`DBIM_CMD_NOP, 16'h0000, 1'b0);
    repeat (4) @(negedge lk2.ck);
  endtask
  // Write burst whose check word is off by one bit
  task lk_wr(input dbim_burst_t w);
    logic [15:0] x;
    x = 16'h0001;
    tick(`DBIM_CMD_WR, 16'h0000, 1'b0);
    for (int k = 0; k < 8; k++) begin
      tick(`DBIM_CMD_NOP, w[k*16 +: 16], 1'b1);
      x ^= w[k*16 +: 16];
    end
    tick(`DBIM_CMD_NOP, x, 1'b1);
    tick(`DBIM_CMD_NOP, 16'h0000, 1'b0);
    repeat (20) @(posedge ref_clk);
  endtask
  initial begin
    logic [5:0] m, prev;
    dbim_burst_t d;
    dbim_be_t b;
    lk2.ck = 1'b0;
    lk2.cmd = `DBIM_CMD_NOP;
    lk2.ctl_dq_o = 16'h0000;
    lk2.ctl_dq_oe_n = 1'b1;
    lk2.ctl_dmdbi_o = 2'h3;
    lk2.ctl_dmdbi_oe_n = 1'b1;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    dev_nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    // Every combination of the four pin-function bits; a refused one leaves the mode alone
    prev = 6'h00;
    for (int c = 0; c < 16; c++) begin
      m = 6'(c);
      req(0, m, '0, '0);
      chk("cfg_bad", cfg_bad, m[3] | (m[1] & m[2]));
      if (!(m[3] | (m[1] & m[2]))) prev = m;
      chk("cfg_q", cfg_q, prev);
    end
    // Write, read back and readout in each legal pin-function mode, plus two with the check word on
    foreach (mt[j]) begin
      req(0, mt[j], '0, '0);
      d = {$random(seed), $random(seed), $random(seed), $random(seed)};
      if (mt[j] == 6'h03) d = {8{16'h0F07}};
      b = 16'($random(seed));
      for (int i = 0; i < 16; i++)
        if (b[i] || !mt[j][2]) exp_mem[i*8 +: 8] = d[i*8 +: 8];
      req(1, mt[j], d, b);
      expq.push_back(exp_mem);
      req(2, mt[j], d, b);
      expq.push_back({16{mpr_data}});
      req(3, mt[j], d, b);
      chk("crc_ok", crc_err, 0);
    end
    // Bad check word: dropped under mask, stored without
    d = {$random(seed), $random(seed), $random(seed), $random(seed)};
    lk_mrs(6'h14);
    lk_wr(d);
    chk("drop_cnt", nwe, 0);
    chk("err_set", err_b, 1);
    lk_mrs(6'h34);
    chk("err_keep", err_b, 1);
    lk_mrs(6'h10);
    chk("err_clr", err_b, 0);
    lk_wr(d);
    chk("keep_cnt", nwe, 1);
    chk("keep_dat", last_b, d);
    chk("keep_be", be_b, 16'hFFFF);
    chk("err_again", err_b, 1);
    chk("rd_fetch", nre, 8);
    chk("rd_left", expq.size(), 0);
    end_sim();
  end
endmodule

// ### hw/dbim_ctl_end.sv
// Controller-side encoder, mask driver and read decoder
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "dbim_regs.svh"
module dbim_ctl_end (
  dbim_if.ctl link,
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cfg_wr,
  input wire dbim_pkg::dbim_mode_t cfg_d,
  input wire logic wr_req,
  input wire dbim_pkg::dbim_burst_t wr_data,
  input wire dbim_pkg::dbim_be_t wr_be,
  input wire logic rd_req,
  input wire logic mpr_req,
  output logic busy,
  output dbim_pkg::dbim_mode_t cfg_q,
  output logic cfg_bad,
  output logic rd_valid,
  output dbim_pkg::dbim_burst_t rd_data
);
  import dbim_pkg::*;

  localparam int LANES = `DBIM_LANES;
  localparam bit HAS_TDQS = (`DBIM_DQ_W == 8);

  dbim_ctl_state_t st_q;
  logic ck_q;
  logic [2:0] cnt_q;
  dbim_cmd_t kind_q;
  dbim_cmd_t cmd_q;
  dbim_mode_t mode_q;
  dbim_mode_t next_mode_q;
  logic busy_q;
  logic bad_q;
  logic rvalid_q;
  dbim_burst_t tx_q;
  dbim_be_t pin_q;
  dbim_burst_t rx_q;
  logic [`DBIM_DQ_W-1:0] crc_q;
  logic [`DBIM_DQ_W-1:0] dq_q;
  logic dq_oe_n_q;
  logic [LANES-1:0] dm_q;
  logic dm_oe_n_q;

  logic illegal;
  dbim_burst_t enc;
  dbim_be_t enc_pin;
  logic [`DBIM_DQ_W-1:0] tx_beat;
  logic [`DBIM_DQ_W-1:0] rx_dec;

  // Forbidden pin-function combinations are refused
  assign illegal = (cfg_d.wr_dbi && cfg_d.dm) ||
                   (cfg_d.tdqs && (!HAS_TDQS || cfg_d.rd_dbi ||
                    cfg_d.wr_dbi || cfg_d.dm));

  // Byte encode: mask enable or inversion flag on the shared pin
  genvar g;
  for (g = 0; g < `DBIM_BE_W; g++) begin : g_byte
    logic [7:0] b;
    logic inv;
    assign b = wr_data[g*8 +: 8];
    assign inv = mode_q.wr_dbi && dbim_inv_needed(b);
    assign enc[g*8 +: 8] = inv ? ~b : b;
    assign enc_pin[g] = mode_q.dm ? wr_be[g] : !inv;
  end

  // Read decode; register readout is never inverted
  for (g = 0; g < LANES; g++) begin : g_lane
    assign rx_dec[g*8 +: 8] =
      (mode_q.rd_dbi && kind_q != `DBIM_CMD_MPR && !link.dmdbi[g]) ?
      ~link.dq[g*8 +: 8] : link.dq[g*8 +: 8];
  end

  assign tx_beat = tx_q[{cnt_q, 4'h0} +: `DBIM_DQ_W];

  // Link clock at half the reference rate
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      ck_q <= 1'b0;
    end else begin
      ck_q <= ~ck_q;
    end
  end

  // Transfer sequencer; link signals change as the link clock falls
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q <= CTL_IDLE;
      cnt_q <= 3'h0;
      kind_q <= `DBIM_CMD_NOP;
      cmd_q <= `DBIM_CMD_NOP;
      mode_q <= `DBIM_MODE_RST;
      next_mode_q <= `DBIM_MODE_RST;
      busy_q <= 1'b0;
      bad_q <= 1'b0;
      rvalid_q <= 1'b0;
      tx_q <= '0;
      pin_q <= '1;
      rx_q <= '0;
      crc_q <= '0;
      dq_q <= '0;
      dq_oe_n_q <= 1'b1;
      dm_q <= '1;
      dm_oe_n_q <= 1'b1;
    end else begin
      rvalid_q <= 1'b0;
      case (st_q)
        CTL_IDLE: begin
          if (cfg_wr) begin
            bad_q <= illegal;
            if (!illegal) begin
              kind_q <= `DBIM_CMD_MRS;
              next_mode_q <= cfg_d;
              busy_q <= 1'b1;
              st_q <= CTL_ISSUE;
            end
          end else if (wr_req) begin
            kind_q <= `DBIM_CMD_WR;
            tx_q <= enc;
            pin_q <= enc_pin;
            busy_q <= 1'b1;
            st_q <= CTL_ISSUE;
          end else if (rd_req || mpr_req) begin
            kind_q <= mpr_req ? `DBIM_CMD_MPR : `DBIM_CMD_RD;
            busy_q <= 1'b1;
            st_q <= CTL_ISSUE;
          end
        end
        CTL_ISSUE: if (ck_q) begin
          cmd_q <= kind_q;
          cnt_q <= 3'h0;
          crc_q <= '0;
          if (kind_q == `DBIM_CMD_MRS) begin
            dq_q <= {{(`DBIM_DQ_W-`DBIM_MODE_W){1'b0}}, next_mode_q};
            dq_oe_n_q <= 1'b0;
            mode_q <= next_mode_q;
            st_q <= CTL_END;
          end else if (kind_q == `DBIM_CMD_WR) begin
            st_q <= CTL_BEAT;
          end else begin
            st_q <= CTL_RWAIT;
          end
        end
        CTL_BEAT: if (ck_q) begin
          cmd_q <= `DBIM_CMD_NOP;
          dq_q <= tx_beat;
          dq_oe_n_q <= 1'b0;
          dm_q <= pin_q[{cnt_q, 1'b0} +: LANES];
          dm_oe_n_q <= mode_q.tdqs;
          crc_q <= crc_q ^ tx_beat;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `DBIM_LAST_BEAT) begin
            st_q <= mode_q.crc_en ? CTL_CRC : CTL_END;
          end
        end
        CTL_CRC: if (ck_q) begin
          dq_q <= crc_q;
          dm_q <= '1;
          st_q <= CTL_END;
        end
        CTL_RWAIT: if (ck_q) begin
          cmd_q <= `DBIM_CMD_NOP;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `DBIM_RD_WAIT) begin
            cnt_q <= 3'h0;
            st_q <= CTL_RBEAT;
          end
        end
        CTL_RBEAT: if (ck_q) begin
          rx_q[{cnt_q, 4'h0} +: `DBIM_DQ_W] <= rx_dec;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == `DBIM_LAST_BEAT) begin
            st_q <= CTL_END;
          end
        end
        CTL_END: if (ck_q) begin
          cmd_q <= `DBIM_CMD_NOP;
          dq_oe_n_q <= 1'b1;
          dm_oe_n_q <= 1'b1;
          busy_q <= 1'b0;
          rvalid_q <= (kind_q == `DBIM_CMD_RD) ||
                      (kind_q == `DBIM_CMD_MPR);
          st_q <= CTL_IDLE;
        end
        default: st_q <= CTL_IDLE;
      endcase
    end
  end

  // Ports from flops
  assign busy = busy_q;
  assign cfg_q = mode_q;
  assign cfg_bad = bad_q;
  assign rd_valid = rvalid_q;
  assign rd_data = rx_q;
  assign link.ck = ck_q;
  assign link.cmd = cmd_q;
  assign link.ctl_dq_o = dq_q;
  assign link.ctl_dq_oe_n = dq_oe_n_q;
  assign link.ctl_dmdbi_o = dm_q;
  assign link.ctl_dmdbi_oe_n = dm_oe_n_q;

endmodule

// ### hw/dbim_dram_end.sv
// DRAM-side bus inversion, write mask and write check data path
`timescale 1ns/100ps
// Functional notes
// - No inversion on 4-bit-wide parts
// - One shared pin: inversion, mask or strobe
// - Read and write inversion enabled separately
// - Controller never sets write inversion with mask
// - Strobe only with inversion and mask off
// - Register-readout data never inversion encoded
// - Write flag low inverts stored byte
// - Eight beats, one flag per lane per beat
// - Over four zeros: invert, flag low
// - Four or fewer zeros: plain, flag high
// - Read flag driven every beat, every lane
// - Mask acts on writes only
// - Mask flag low blocks that byte
// - Check passes before masked write commits
// - Masked write with bad check dropped
// - Unmasked write with bad check still stored
// - Error bit sticks until written zero
`include "dbim_regs.svh"
module dbim_dram_end (
  dbim_if.dev link,
  input wire logic nrst,
  output logic arr_we,
  output dbim_pkg::dbim_burst_t arr_wdata,
  output dbim_pkg::dbim_be_t arr_be,
  output logic arr_re,
  input wire dbim_pkg::dbim_burst_t arr_rdata,
  input wire logic [7:0] mpr_data,
  output logic crc_err
);
  import dbim_pkg::*;

  localparam int LANES = `DBIM_LANES;
  // Inversion and mask exist only on byte-wide lanes or wider
  localparam bit HAS_DBI = (`DBIM_DQ_W != 4);
  // Termination strobe exists only on byte-wide parts
  localparam bit HAS_TDQS = (`DBIM_DQ_W == 8);

  dbim_dev_state_t st_q;
  logic [2:0] beat_q;
  dbim_mode_t mode_q;
  logic mpr_q;
  logic crc_bad_q;
  logic [`DBIM_DQ_W-1:0] crc_acc_q;
  dbim_burst_t rbuf_q;
  dbim_burst_t wdata_q;
  dbim_be_t be_q;
  logic we_q;
  logic re_q;
  logic err_q;
  logic [`DBIM_DQ_W-1:0] dq_q;
  logic dq_oe_n_q;
  logic [LANES-1:0] flag_q;
  logic flag_oe_n_q;

  logic tdqs_on;
  logic mask_on;
  logic winv_on;
  logic rinv_on;
  logic mrs_hit;
  dbim_burst_t rd_src;
  logic [`DBIM_DQ_W-1:0] wr_beat;
  logic [LANES-1:0] wr_keep;
  logic [`DBIM_DQ_W-1:0] rd_beat;
  logic [LANES-1:0] rd_flag;

  // Meaning of the shared pin: strobe, then mask, then inversion
  assign tdqs_on = HAS_TDQS && mode_q.tdqs;
  assign mask_on = HAS_DBI && mode_q.dm && !tdqs_on;
  assign winv_on = HAS_DBI && mode_q.wr_dbi && !mode_q.dm && !tdqs_on;
  assign rinv_on = HAS_DBI && mode_q.rd_dbi && !tdqs_on;
  assign mrs_hit = (st_q == DEV_IDLE) && (link.cmd == `DBIM_CMD_MRS);

  // First read beat straight from the array, later ones from the copy
  assign rd_src = (beat_q == 3'h0) ? arr_rdata : rbuf_q;

  // Per-lane decode of write beats and encode of read beats
  genvar g;
  for (g = 0; g < LANES; g++) begin : g_lane
    localparam logic [3:0] OFS = 4'(g * 8);
    logic [7:0] rx;
    logic [7:0] tx;
    logic heavy;
    assign rx = link.dq[g*8 +: 8];
    assign wr_beat[g*8 +: 8] = (winv_on && !link.dmdbi[g]) ? ~rx : rx;
    assign wr_keep[g] = !(mask_on && !link.dmdbi[g]);
    assign tx = mpr_q ? mpr_data : rd_src[{beat_q, OFS} +: 8];
    assign heavy = dbim_inv_needed(tx);
    // Register readout bypasses the encoder
    assign rd_flag[g] = !(rinv_on && !mpr_q && heavy);
    assign rd_beat[g*8 +: 8] = rd_flag[g] ? tx : ~tx;
  end

  // Burst sequencer on the link clock
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      st_q <= DEV_IDLE;
      beat_q <= 3'h0;
      mpr_q <= 1'b0;
    end else begin
      case (st_q)
        DEV_IDLE: begin
          beat_q <= 3'h0;
          if (link.cmd == `DBIM_CMD_WR) begin
            st_q <= DEV_WR;
          end else if (link.cmd == `DBIM_CMD_RD ||
                       link.cmd == `DBIM_CMD_MPR) begin
            st_q <= DEV_RWAIT;
            mpr_q <= (link.cmd == `DBIM_CMD_MPR);
          end
        end
        DEV_WR: begin
          beat_q <= beat_q + 3'h1;
          if (beat_q == `DBIM_LAST_BEAT) begin
            st_q <= mode_q.crc_en ? DEV_CRC : DEV_COMMIT;
          end
        end
        DEV_CRC: st_q <= DEV_COMMIT;
        DEV_COMMIT: st_q <= DEV_IDLE;
        DEV_RWAIT: st_q <= DEV_RD;
        DEV_RD: begin
          beat_q <= beat_q + 3'h1;
          if (beat_q == `DBIM_LAST_BEAT) begin
            st_q <= DEV_IDLE;
          end
        end
        default: st_q <= DEV_IDLE;
      endcase
    end
  end

  // Mode word taken from dq on a mode write
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      mode_q <= `DBIM_MODE_RST;
    end else if (mrs_hit) begin
      mode_q <= link.dq[`DBIM_MODE_W-1:0];
    end
  end

  // Write beat capture, byte enables and running check word
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      wdata_q <= '0;
      be_q <= '0;
      crc_acc_q <= '0;
    end else if (st_q == DEV_WR) begin
      wdata_q[{beat_q, 4'h0} +: `DBIM_DQ_W] <= wr_beat;
      be_q[{beat_q, 1'b0} +: LANES] <= wr_keep;
      crc_acc_q <= crc_acc_q ^ link.dq;
    end else if (st_q == DEV_IDLE) begin
      crc_acc_q <= '0;
    end
  end

  // Check word compare on the beat after the data
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      crc_bad_q <= 1'b0;
    end else if (st_q == DEV_CRC) begin
      crc_bad_q <= (crc_acc_q != link.dq);
    end else if (st_q == DEV_IDLE) begin
      crc_bad_q <= 1'b0;
    end
  end

  // Commit pulse; a masked write with a bad check is dropped whole
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      we_q <= 1'b0;
    end else begin
      we_q <= (st_q == DEV_COMMIT) &&
              !(mode_q.crc_en && mask_on && crc_bad_q);
    end
  end

  // Sticky error bit; detection wins over a clearing mode write
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      err_q <= 1'b0;
    end else if (st_q == DEV_COMMIT && mode_q.crc_en && crc_bad_q) begin
      err_q <= 1'b1;
    end else if (mrs_hit && !link.dq[`DBIM_MODE_CRC_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // Array fetch request and copy of the fetched burst
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      re_q <= 1'b0;
      rbuf_q <= '0;
    end else begin
      re_q <= (st_q == DEV_IDLE) && (link.cmd == `DBIM_CMD_RD);
      if (st_q == DEV_RD && beat_q == 3'h0) begin
        rbuf_q <= arr_rdata;
      end
    end
  end

  // Read drivers; flag pin driven only when read inversion is on
  always_ff @(posedge link.ck) begin
    if (!nrst) begin
      dq_q <= '0;
      dq_oe_n_q <= 1'b1;
      flag_q <= '1;
      flag_oe_n_q <= 1'b1;
    end else if (st_q == DEV_RD) begin
      dq_q <= rd_beat;
      flag_q <= rd_flag;
      dq_oe_n_q <= 1'b0;
      flag_oe_n_q <= !rinv_on;
    end else begin
      dq_oe_n_q <= 1'b1;
      flag_oe_n_q <= 1'b1;
    end
  end

  // Ports from flops
  assign arr_we = we_q;
  assign arr_wdata = wdata_q;
  assign arr_be = be_q;
  assign arr_re = re_q;
  assign crc_err = err_q;
  assign link.dev_dq_o = dq_q;
  assign link.dev_dq_oe_n = dq_oe_n_q;
  assign link.dev_dmdbi_o = flag_q;
  assign link.dev_dmdbi_oe_n = flag_oe_n_q;

endmodule

// ### hw/dbim_if.sv
// Link between controller and DRAM data path, with pin resolution
`timescale 1ns/100ps
`include "dbim_regs.svh"
interface dbim_if;
  logic ck;
  logic [2:0] cmd;
  logic [`DBIM_DQ_W-1:0] ctl_dq_o;
  logic ctl_dq_oe_n;
  logic [`DBIM_LANES-1:0] ctl_dmdbi_o;
  logic ctl_dmdbi_oe_n;
  logic [`DBIM_DQ_W-1:0] dev_dq_o;
  logic dev_dq_oe_n;
  logic [`DBIM_LANES-1:0] dev_dmdbi_o;
  logic dev_dmdbi_oe_n;
  logic [`DBIM_DQ_W-1:0] dq;
  logic [`DBIM_LANES-1:0] dmdbi;
  // Wire levels; undriven lines are terminated high
  assign dq = !dev_dq_oe_n ? dev_dq_o :
              (!ctl_dq_oe_n ? ctl_dq_o : '1);
  assign dmdbi = !dev_dmdbi_oe_n ? dev_dmdbi_o :
                 (!ctl_dmdbi_oe_n ? ctl_dmdbi_o : '1);
  modport ctl (output ck, output cmd, output ctl_dq_o,
    output ctl_dq_oe_n, output ctl_dmdbi_o, output ctl_dmdbi_oe_n,
    input dq, input dmdbi);
  modport dev (input ck, input cmd, output dev_dq_o,
    output dev_dq_oe_n, output dev_dmdbi_o, output dev_dmdbi_oe_n,
    input dq, input dmdbi);
endinterface

// ### hw/dbim_pkg.sv
// Types shared by both ends of the inversion and mask link
`include "dbim_regs.svh"
package dbim_pkg;
  typedef logic [`DBIM_BURST_W-1:0] dbim_burst_t;
  typedef logic [`DBIM_BE_W-1:0] dbim_be_t;
  typedef logic [2:0] dbim_cmd_t;
  // Field order matches the mode word bit positions
  typedef struct packed {
    logic crc_err;
    logic crc_en;
    logic tdqs;
    logic dm;
    logic wr_dbi;
    logic rd_dbi;
  } dbim_mode_t;
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_WR = 3'h1,
    DEV_CRC = 3'h3,
    DEV_COMMIT = 3'h2,
    DEV_RWAIT = 3'h4,
    DEV_RD = 3'h5
  } dbim_dev_state_t;
  typedef enum logic [2:0] {
    CTL_IDLE = 3'h0,
    CTL_ISSUE = 3'h1,
    CTL_BEAT = 3'h3,
    CTL_CRC = 3'h2,
    CTL_RWAIT = 3'h5,
    CTL_RBEAT = 3'h7,
    CTL_END = 3'h6
  } dbim_ctl_state_t;
  // True when a byte holds more zero bits than allowed
  function automatic logic dbim_inv_needed(input logic [7:0] b);
    return ($countones(~b) > `DBIM_ZERO_MAX);
  endfunction
endpackage

// ### hw/dbim_regs.svh
// Constants for the bus inversion and write mask link
`ifndef DBIM_REGS_SVH
`define DBIM_REGS_SVH
// Link geometry
`define DBIM_DQ_W 16
`define DBIM_LANES 2
`define DBIM_BEATS 8
`define DBIM_BURST_W 128
`define DBIM_BE_W 16
`define DBIM_ZERO_MAX 4
// Last beat index of a burst
`define DBIM_LAST_BEAT 3'h7
// Mode word bit positions, carried on dq during a mode write
`define DBIM_MODE_W 6
`define DBIM_MODE_RD_DBI 0
`define DBIM_MODE_WR_DBI 1
`define DBIM_MODE_DM 2
`define DBIM_MODE_TDQS 3
`define DBIM_MODE_CRC_EN 4
`define DBIM_MODE_CRC_ERR 5
`define DBIM_MODE_RST 6'h00
// Link command codes
`define DBIM_CMD_NOP 3'h0
`define DBIM_CMD_WR 3'h1
`define DBIM_CMD_RD 3'h2
`define DBIM_CMD_MRS 3'h3
`define DBIM_CMD_MPR 3'h4
// Last read wait count; the wait between command and first sampled beat is one tick longer
`define DBIM_RD_WAIT 3'h1
`endif
